// ---- src/pdcr_pkg.sv ----
package pdcr_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_FB_BYP   = 7'h03;
    localparam logic [6:0] ADDR_MF_MSB   = 7'h08;
    localparam logic [6:0] ADDR_MF_LSB   = 7'h09;
    localparam logic [6:0] ADDR_S1_BYP   = 7'h0a;
    localparam logic [6:0] ADDR_S2_IN    = 7'h0c;
    localparam logic [6:0] ADDR_S1_CP    = 7'h10;
    localparam logic [6:0] ADDR_OSC_OFS  = 7'h11;
    localparam logic [6:0] ADDR_AMP_CP   = 7'h12;
    localparam logic [6:0] ADDR_IFC_LOCK = 7'h1f;
    // Writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_FB_BYP   = 8'h81;
    localparam logic [7:0] MASK_MF_MSB   = 8'h01;
    localparam logic [7:0] MASK_MF_LSB   = 8'hff;
    localparam logic [7:0] MASK_S1_BYP   = 8'h01;
    localparam logic [7:0] MASK_S2_IN    = 8'hff;
    localparam logic [7:0] MASK_S1_CP    = 8'hdf;
    localparam logic [7:0] MASK_OSC_OFS  = 8'hff;
    localparam logic [7:0] MASK_AMP_CP   = 8'h7f;
    localparam logic [7:0] MASK_IFC_LOCK = 8'hf7;
    // Reset values
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_MF_LSB    = 8'h1e;
    // Field positions
    localparam int DOUBLER_BIT  = 7;
    localparam int SOURCE_BIT   = 6;
    localparam int LMASK_BIT    = 7;
    localparam int SPIMODE_BIT  = 6;
    localparam int STLEVEL_BIT  = 5;
    localparam int SPILEVEL_BIT = 4;
    localparam int S2BYP_BIT    = 0;
    localparam int S1BYP_BIT    = 0;
    localparam int MF_MSB_BIT   = 0;
    // Divider limits
    localparam logic [8:0] MF_MIN        = 9'h008;
    localparam logic [5:0] PF_BYPASS     = 6'h00;
    localparam logic [5:0] PF_UNITY      = 6'h01;
    // Serial frame: 8 command bits then 8 data bits
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [2:0] FIRST_BIT     = 3'h0;

    typedef struct packed {
        logic [7:0] fb_byp;
        logic [7:0] mf_msb;
        logic [7:0] mf_lsb;
        logic [7:0] s1_byp;
        logic [7:0] s2_in;
        logic [7:0] s1_cp;
        logic [7:0] osc_ofs;
        logic [7:0] amp_cp;
        logic [7:0] ifc_lock;
    } pdcr_regs_t;

    typedef enum logic [1:0] {
        ST_CMD  = 2'b00,
        ST_DATA = 2'b01,
        ST_DONE = 2'b10
    } pdcr_state_t;
endpackage

// ---- src/pdcr_regs.sv ----
`timescale 1ns/100ps
// Contract
// - Input divider zero, the reset value, bypasses the divider.
// - Doubler select 0 feeds stage two with divided reference.
// - Doubler select 1 feeds doubled reference; input divider ignored.
// - Source select 0 keeps stage two enabled, feeding channel dividers.
// - Source select 1 disables, bypasses stage two; stage one feeds dividers.
// - Lock mask 0 lets stage one lock loss reach lock pin.
// - SPI mode 0 uses bidirectional data pin, serial out high impedance.
// - SPI mode 1 takes input on data pin, reads on serial out.
// - SPI level select: 0 for 1.8 V, 1 for 3.3 V.
// - Status level select: 0 for 1.8 V, 1 for 3.3 V.
module pdcr_regs (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_sclk,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_serial_data_pin,
    output logic            o_serial_data_pin,
    output logic            o_serial_data_pin_oe,
    output logic            o_serial_out_pin,
    output logic            o_serial_out_pin_oe,
    input  wire logic       i_stage1_lock_loss,
    input  wire logic       i_stage2_lock_loss,
    output logic            o_lock_pin,
    output logic [8:0]      o_stage2_prescale_div,
    output logic            o_prescale_valid,
    output logic [5:0]      o_stage2_input_div,
    output logic            o_input_div_bypass,
    output logic [5:0]      o_ref_div_ratio,
    output logic            o_doubler_select,
    output logic            o_stage2_enable,
    output logic            o_output_source_select,
    output logic            o_stage1_bypass_mux,
    output logic            o_stage2_bypass_bit,
    output logic            o_spi_level_select,
    output logic            o_status_level_select
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    function automatic pdcr_pkg::pdcr_regs_t reg_write(
        input pdcr_pkg::pdcr_regs_t r, input logic [6:0] a,
        input logic [7:0] d);
        pdcr_pkg::pdcr_regs_t w;
        w = r;
        if (a == pdcr_pkg::ADDR_FB_BYP) begin
            w.fb_byp = d & pdcr_pkg::MASK_FB_BYP;
        end else if (a == pdcr_pkg::ADDR_MF_MSB) begin
            w.mf_msb = d & pdcr_pkg::MASK_MF_MSB;
        end else if (a == pdcr_pkg::ADDR_MF_LSB) begin
            w.mf_lsb = d & pdcr_pkg::MASK_MF_LSB;
        end else if (a == pdcr_pkg::ADDR_S1_BYP) begin
            w.s1_byp = d & pdcr_pkg::MASK_S1_BYP;
        end else if (a == pdcr_pkg::ADDR_S2_IN) begin
            w.s2_in = d & pdcr_pkg::MASK_S2_IN;
        end else if (a == pdcr_pkg::ADDR_S1_CP) begin
            w.s1_cp = d & pdcr_pkg::MASK_S1_CP;
        end else if (a == pdcr_pkg::ADDR_OSC_OFS) begin
            w.osc_ofs = d & pdcr_pkg::MASK_OSC_OFS;
        end else if (a == pdcr_pkg::ADDR_AMP_CP) begin
            w.amp_cp = d & pdcr_pkg::MASK_AMP_CP;
        end else if (a == pdcr_pkg::ADDR_IFC_LOCK) begin
            w.ifc_lock = d & pdcr_pkg::MASK_IFC_LOCK;
        end
        return w;
    endfunction

    function automatic logic [7:0] reg_read(
        input pdcr_pkg::pdcr_regs_t r, input logic [6:0] a);
        logic [7:0] q;
        q = 8'h00;
        if (a == pdcr_pkg::ADDR_FB_BYP) begin
            q = r.fb_byp;
        end else if (a == pdcr_pkg::ADDR_MF_MSB) begin
            q = r.mf_msb;
        end else if (a == pdcr_pkg::ADDR_MF_LSB) begin
            q = r.mf_lsb;
        end else if (a == pdcr_pkg::ADDR_S1_BYP) begin
            q = r.s1_byp;
        end else if (a == pdcr_pkg::ADDR_S2_IN) begin
            q = r.s2_in;
        end else if (a == pdcr_pkg::ADDR_S1_CP) begin
            q = r.s1_cp;
        end else if (a == pdcr_pkg::ADDR_OSC_OFS) begin
            q = r.osc_ofs;
        end else if (a == pdcr_pkg::ADDR_AMP_CP) begin
            q = r.amp_cp;
        end else if (a == pdcr_pkg::ADDR_IFC_LOCK) begin
            q = r.ifc_lock;
        end
        return q;
    endfunction

    pdcr_pkg::pdcr_regs_t  regs_reg, regs_next;
    pdcr_pkg::pdcr_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [6:0] shift_reg, shift_next;
    logic [6:0] addr_reg, addr_next;
    logic       rd_reg, rd_next;
    logic [7:0] tx_reg, tx_next;
    logic       sclk_prev_reg;
    logic       rise, fall, drive;
    logic [7:0] byte_in;
    logic [8:0] mf;
    logic [5:0] pf;

    assign rise    = i_sclk & ~sclk_prev_reg;
    assign fall    = ~i_sclk & sclk_prev_reg;
    assign byte_in = {shift_reg, i_serial_data_pin};

    // Serial frame: R/W bit, 7-bit address, 8 data bits, MSB first
    always_comb begin
        regs_next  = regs_reg;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        addr_next  = addr_reg;
        rd_next    = rd_reg;
        tx_next    = tx_reg;
        if (i_chip_select_n) begin
            state_next = pdcr_pkg::ST_CMD;
            cnt_next   = pdcr_pkg::FIRST_BIT;
            rd_next    = 1'b0;
        end else begin
            case (state_reg)
                pdcr_pkg::ST_CMD: begin
                    if (rise) begin
                        shift_next = byte_in[6:0];
                        cnt_next   = cnt_reg + 3'h1;
                        if (cnt_reg == pdcr_pkg::LAST_BIT) begin
                            rd_next    = byte_in[7];
                            addr_next  = byte_in[6:0];
                            tx_next    = reg_read(regs_reg, byte_in[6:0]);
                            state_next = pdcr_pkg::ST_DATA;
                        end
                    end
                end
                pdcr_pkg::ST_DATA: begin
                    if (rise) begin
                        shift_next = byte_in[6:0];
                        cnt_next   = cnt_reg + 3'h1;
                        if (cnt_reg == pdcr_pkg::LAST_BIT) begin
                            if (!rd_reg) begin
                                regs_next = reg_write(regs_reg, addr_reg,
                                                      byte_in);
                            end
                            state_next = pdcr_pkg::ST_DONE;
                        end
                    end else if (fall && cnt_reg != pdcr_pkg::FIRST_BIT) begin
                        tx_next = {tx_reg[6:0], 1'b0};
                    end
                end
                default: begin
                    state_next = pdcr_pkg::ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            regs_reg        <= '0;
            regs_reg.mf_lsb <= pdcr_pkg::RST_MF_LSB;
            state_reg       <= pdcr_pkg::ST_CMD;
            cnt_reg         <= 3'h0;
            shift_reg       <= 7'h00;
            addr_reg        <= 7'h00;
            rd_reg          <= 1'b0;
            tx_reg          <= 8'h00;
            sclk_prev_reg   <= 1'b0;
        end else if (i_ce) begin
            regs_reg      <= regs_next;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            shift_reg     <= shift_next;
            addr_reg      <= addr_next;
            rd_reg        <= rd_next;
            tx_reg        <= tx_next;
            sclk_prev_reg <= i_sclk;
        end
    end

    // Output stage follows the next register image
    assign mf    = {regs_next.mf_msb[pdcr_pkg::MF_MSB_BIT], regs_next.mf_lsb};
    assign pf    = regs_next.s2_in[5:0];
    assign drive = ~i_chip_select_n && rd_next
                   && state_next == pdcr_pkg::ST_DATA;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_serial_data_pin      <= 1'b0;
            o_serial_data_pin_oe   <= 1'b0;
            o_serial_out_pin       <= 1'b0;
            o_serial_out_pin_oe    <= 1'b0;
            o_lock_pin             <= 1'b0;
            o_stage2_prescale_div  <= {1'b0, pdcr_pkg::RST_MF_LSB};
            o_prescale_valid       <= 1'b1;
            o_stage2_input_div     <= pdcr_pkg::PF_BYPASS;
            o_input_div_bypass     <= 1'b1;
            o_ref_div_ratio        <= pdcr_pkg::PF_UNITY;
            o_doubler_select       <= 1'b0;
            o_stage2_enable        <= 1'b1;
            o_output_source_select <= 1'b0;
            o_stage1_bypass_mux    <= 1'b0;
            o_stage2_bypass_bit    <= 1'b0;
            o_spi_level_select     <= 1'b0;
            o_status_level_select  <= 1'b0;
        end else if (i_ce) begin
            o_serial_data_pin      <= tx_next[7];
            o_serial_out_pin       <= tx_next[7];
            o_serial_data_pin_oe   <= drive
                && !regs_next.ifc_lock[pdcr_pkg::SPIMODE_BIT];
            o_serial_out_pin_oe    <= drive
                && regs_next.ifc_lock[pdcr_pkg::SPIMODE_BIT];
            o_lock_pin <= !((i_stage1_lock_loss
                && !regs_next.ifc_lock[pdcr_pkg::LMASK_BIT])
                || i_stage2_lock_loss);
            o_stage2_prescale_div  <= mf;
            o_prescale_valid       <= mf >= pdcr_pkg::MF_MIN;
            o_stage2_input_div     <= pf;
            o_input_div_bypass     <= pf == pdcr_pkg::PF_BYPASS;
            if (regs_next.s2_in[pdcr_pkg::DOUBLER_BIT]) begin
                o_ref_div_ratio <= pdcr_pkg::PF_UNITY;
            end else if (pf == pdcr_pkg::PF_BYPASS) begin
                o_ref_div_ratio <= pdcr_pkg::PF_UNITY;
            end else begin
                o_ref_div_ratio <= pf;
            end
            o_doubler_select <= regs_next.s2_in[pdcr_pkg::DOUBLER_BIT];
            o_stage2_enable  <= !regs_next.s2_in[pdcr_pkg::SOURCE_BIT];
            o_output_source_select
                <= regs_next.s2_in[pdcr_pkg::SOURCE_BIT];
            o_stage1_bypass_mux <= regs_next.s1_byp[pdcr_pkg::S1BYP_BIT];
            o_stage2_bypass_bit <= regs_next.fb_byp[pdcr_pkg::S2BYP_BIT];
            o_spi_level_select
                <= regs_next.ifc_lock[pdcr_pkg::SPILEVEL_BIT];
            o_status_level_select
                <= regs_next.ifc_lock[pdcr_pkg::STLEVEL_BIT];
        end
    end

    property p_prescale_valid;
        o_prescale_valid == (o_stage2_prescale_div >= 9'h008);
    endproperty
    a_prescale_valid: assert property (p_prescale_valid)
        else $error("prescale valid flag wrong");
    property p_input_div;
        o_stage2_input_div == regs_reg.s2_in[5:0];
    endproperty
    a_input_div: assert property (p_input_div)
        else $error("input divider output differs from register");
    property p_bypass;
        o_input_div_bypass == (o_stage2_input_div == 6'h00);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("input divider bypass wrong");
    property p_divided;
        !o_doubler_select && !o_input_div_bypass
            |-> o_ref_div_ratio == o_stage2_input_div;
    endproperty
    a_divided: assert property (p_divided)
        else $error("reference ratio not the input divider");
    property p_doubled;
        o_doubler_select |-> o_ref_div_ratio == 6'h01;
    endproperty
    a_doubled: assert property (p_doubled)
        else $error("input divider acts while doubling");
    property p_source;
        o_stage2_enable == !o_output_source_select
            && o_output_source_select == regs_reg.s2_in[6];
    endproperty
    a_source: assert property (p_source)
        else $error("stage two enable and source disagree");
    property p_mask;
        i_ce && regs_next.ifc_lock[7] && !i_stage2_lock_loss |=> o_lock_pin;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked lock loss reached lock pin");
    property p_three_wire;
        !regs_reg.ifc_lock[6] |-> !o_serial_out_pin_oe;
    endproperty
    a_three_wire: assert property (p_three_wire)
        else $error("serial out driven in 3-wire mode");
    property p_four_wire;
        regs_reg.ifc_lock[6] |-> !o_serial_data_pin_oe;
    endproperty
    a_four_wire: assert property (p_four_wire)
        else $error("data pin driven in 4-wire mode");
    property p_levels;
        o_spi_level_select == regs_reg.ifc_lock[4]
            && o_status_level_select == regs_reg.ifc_lock[5];
    endproperty
    a_levels: assert property (p_levels)
        else $error("level selects differ from register");
    property p_write_back;
        i_ce && !i_chip_select_n && state_reg == pdcr_pkg::ST_DATA
            && !rd_reg && rise && cnt_reg == 3'h7
            |=> reg_read(regs_reg, addr_reg)
                == reg_read(reg_write('0, $past(addr_reg), $past(byte_in)),
                            $past(addr_reg));
    endproperty
    a_write_back: assert property (p_write_back)
        else $error("written value does not read back");

    c_read: cover property (o_serial_data_pin_oe ##1 !o_serial_data_pin_oe);
    c_read4: cover property (o_serial_out_pin_oe);
    c_write: cover property (state_reg == pdcr_pkg::ST_DATA && !rd_reg
                             ##1 state_reg == pdcr_pkg::ST_DONE);
    c_double: cover property (o_doubler_select && !o_stage2_enable);
endmodule

// ---- tb/pdcr_spi_host.sv ----
`timescale 1ns/100ps
module pdcr_spi_host (
    input  wire logic i_clk_sys,
    input  wire logic i_dev_sd,
    input  wire logic i_dev_sd_oe,
    input  wire logic i_dev_so,
    input  wire logic i_dev_so_oe,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sd
);
    logic host_oe = 1'b0;
    logic host_d  = 1'b0;
    logic flt     = 1'b0;
    logic so_w;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
    end

    // Released lines toggle so a stale level never passes for data
    always @(posedge i_clk_sys) begin
        flt <= ~flt;
    end
    assign o_sd = i_dev_sd_oe ? i_dev_sd : (host_oe ? host_d : flt);
    assign so_w = i_dev_so_oe ? i_dev_so : flt;

    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] wd, input logic four,
                        output logic [7:0] q, output logic sd_seen,
                        output logic so_seen);
        logic [15:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        sd_seen = 1'b0;
        so_seen = 1'b0;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        host_oe <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            // Let go of the shared line after the device starts driving the read byte
            if (rd && !four && i == 7) begin
                host_oe <= 1'b0;
            end
            host_d <= f[i];
            repeat (3) @(posedge i_clk_sys);
            if (i < 8) begin
                q[i] = four ? so_w : o_sd;
                sd_seen |= i_dev_sd_oe;
                so_seen |= i_dev_so_oe;
            end
            o_sclk <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            o_sclk <= 1'b0;
        end
        repeat (2) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        host_oe <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
endmodule

// ---- tb/tb_pdcr_regs.sv ----
`timescale 1ns/100ps
module tb_pdcr_regs;
    logic       i_clk_sys = 1'b0;
    logic       i_rst     = 1'b1;
    logic       lol1      = 1'b0;
    logic       lol2      = 1'b0;
    logic       sclk, cs_n, sd, sd_o, sd_oe, so, so_oe, lock;
    logic [8:0] pre;
    logic [5:0] idiv, ratio;
    logic       pvalid, ibyp, dbl, s2en, src, s1b, s2b, spil, stl;
    logic       s1, s2;
    int         failures  = 0;
    int         cmp_count = 0;

    always #25 i_clk_sys = ~i_clk_sys;

    pdcr_regs pdcr_regs_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
        .i_sclk(sclk), .i_chip_select_n(cs_n), .i_serial_data_pin(sd),
        .o_serial_data_pin(sd_o), .o_serial_data_pin_oe(sd_oe),
        .o_serial_out_pin(so), .o_serial_out_pin_oe(so_oe),
        .i_stage1_lock_loss(lol1), .i_stage2_lock_loss(lol2),
        .o_lock_pin(lock), .o_stage2_prescale_div(pre),
        .o_prescale_valid(pvalid), .o_stage2_input_div(idiv),
        .o_input_div_bypass(ibyp), .o_ref_div_ratio(ratio),
        .o_doubler_select(dbl), .o_stage2_enable(s2en),
        .o_output_source_select(src), .o_stage1_bypass_mux(s1b),
        .o_stage2_bypass_bit(s2b), .o_spi_level_select(spil),
        .o_status_level_select(stl));

    pdcr_spi_host pdcr_spi_host_i (
        .i_clk_sys(i_clk_sys), .i_dev_sd(sd_o), .i_dev_sd_oe(sd_oe),
        .i_dev_so(so), .i_dev_so_oe(so_oe), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sd(sd));

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {8'h00, e}, {8'h00, g});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        pdcr_spi_host_i.xfer(1'b0, a, d, 1'b0, q, s1, s2);
    endtask

    task automatic rd(input string nm, input logic [6:0] a,
                      input logic four, input logic [7:0] e);
        logic [7:0] q;
        pdcr_spi_host_i.xfer(1'b1, a, 8'h00, four, q, s1, s2);
        chk(nm, {1'b0, e}, {1'b0, q});
    endtask

    task automatic t_reset;
        chk("prescale", 9'h01e, pre);
        chkb("prescale_valid", 1'b1, pvalid);
        chk("input_div", 9'h000, {3'h0, idiv});
        chkb("input_bypass", 1'b1, ibyp);
        chk("ref_ratio", 9'h001, {3'h0, ratio});
        chkb("doubler", 1'b0, dbl);
        chkb("stage2_enable", 1'b1, s2en);
        chkb("spi_level", 1'b0, spil);
        chkb("status_level", 1'b0, stl);
        rd("prescale_lsb", pdcr_pkg::ADDR_MF_LSB, 1'b0, 8'h1e);
        chkb("serial_out_oe", 1'b0, s2);
    endtask

    task automatic t_prescale;
        wr(pdcr_pkg::ADDR_MF_MSB, 8'h01);
        wr(pdcr_pkg::ADDR_MF_LSB, 8'hff);
        chk("prescale_max", 9'h1ff, pre);
        chkb("valid_max", 1'b1, pvalid);
        wr(pdcr_pkg::ADDR_MF_MSB, 8'hfe);
        wr(pdcr_pkg::ADDR_MF_LSB, 8'h07);
        chk("prescale_low", 9'h007, pre);
        chkb("valid_low", 1'b0, pvalid);
        wr(pdcr_pkg::ADDR_MF_LSB, 8'h08);
        chkb("valid_min", 1'b1, pvalid);
        rd("prescale_msb", pdcr_pkg::ADDR_MF_MSB, 1'b0, 8'h00);
    endtask

    task automatic t_input;
        wr(pdcr_pkg::ADDR_S2_IN, 8'h05);
        chk("input_div", 9'h005, {3'h0, idiv});
        chk("ratio_div", 9'h005, {3'h0, ratio});
        chkb("bypass_off", 1'b0, ibyp);
        wr(pdcr_pkg::ADDR_S2_IN, 8'h3f);
        chk("ratio_max", 9'h03f, {3'h0, ratio});
        wr(pdcr_pkg::ADDR_S2_IN, 8'hc5);
        chkb("doubler_on", 1'b1, dbl);
        chkb("stage2_off_dbl", 1'b0, s2en);
        chk("ratio_dbl", 9'h001, {3'h0, ratio});
        wr(pdcr_pkg::ADDR_S2_IN, 8'h40);
        chkb("source_sel", 1'b1, src);
        chkb("stage2_off", 1'b0, s2en);
        chkb("bypass_on", 1'b1, ibyp);
        rd("input_ctrl", pdcr_pkg::ADDR_S2_IN, 1'b0, 8'h40);
        wr(pdcr_pkg::ADDR_S2_IN, 8'h00);
        chkb("stage2_on", 1'b1, s2en);
    endtask

    task automatic t_lock;
        @(posedge i_clk_sys);
        lol1 <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chkb("lock_lost", 1'b0, lock);
        wr(pdcr_pkg::ADDR_IFC_LOCK, 8'h80);
        chkb("lock_masked", 1'b1, lock);
        @(posedge i_clk_sys);
        lol2 <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chkb("lock_stage2", 1'b0, lock);
        @(posedge i_clk_sys);
        lol1 <= 1'b0;
        lol2 <= 1'b0;
        wr(pdcr_pkg::ADDR_IFC_LOCK, 8'h00);
        chkb("lock_clear", 1'b1, lock);
    endtask

    task automatic t_mode;
        logic [6:0] a [5];
        logic [7:0] m [5];
        a = '{pdcr_pkg::ADDR_FB_BYP, pdcr_pkg::ADDR_S1_BYP,
              pdcr_pkg::ADDR_S1_CP, pdcr_pkg::ADDR_OSC_OFS,
              pdcr_pkg::ADDR_AMP_CP};
        m = '{8'h81, 8'h01, 8'hdf, 8'hff, 8'h7f};
        wr(pdcr_pkg::ADDR_IFC_LOCK, 8'hff);
        chkb("spi_level", 1'b1, spil);
        chkb("status_level", 1'b1, stl);
        rd("ifc_4wire", pdcr_pkg::ADDR_IFC_LOCK, 1'b1, 8'hf7);
        chkb("data_oe_4w", 1'b0, s1);
        chkb("out_oe_4w", 1'b1, s2);
        wr(pdcr_pkg::ADDR_IFC_LOCK, 8'h00);
        rd("ifc_3wire", pdcr_pkg::ADDR_IFC_LOCK, 1'b0, 8'h00);
        chkb("data_oe_3w", 1'b1, s1);
        chkb("out_oe_3w", 1'b0, s2);
        wr(7'h20, 8'hff);
        rd("unmapped", 7'h20, 1'b0, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(a[i], 8'hff);
            rd("masked_reg", a[i], 1'b0, m[i]);
        end
        chkb("s1_bypass", 1'b1, s1b);
        chkb("s2_bypass", 1'b1, s2b);
    endtask

    task automatic t_rerst;
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk("prescale_rst", 9'h01e, pre);
        chkb("s1_bypass_rst", 1'b0, s1b);
        rd("prescale_lsb_rst", pdcr_pkg::ADDR_MF_LSB, 1'b0, 8'h1e);
    endtask

    task automatic report_and_stop;
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        t_reset;
        t_prescale;
        t_input;
        t_lock;
        t_mode;
        t_rerst;
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        failures++;
        report_and_stop;
    end
endmodule
